//--- src/nand_host_defs.svh
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH

// Clock rate in MHz; the controller clock is 10 MHz
`define CLK_MHZ 10
// Least strobe low time and least strobe high time, in ns
`define T_STROBE_LOW_NS 20
`define T_STROBE_HIGH_NS 20
// Least time rounded up to whole cycles, never below one
`define CYC_UP(ns) ((((ns) * `CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `CLK_MHZ + 999) / 1000))
`define STROBE_LOW_CYC `CYC_UP(`T_STROBE_LOW_NS)
`define STROBE_HIGH_CYC `CYC_UP(`T_STROBE_HIGH_NS)
// Idle cycles before chip select is released into standby
`define IDLE_CE_CYC 8
`define CNT_W 4
// Width of the command and address field on the bus
`define CA_W 8

`endif

//--- src/nand_host_pkg.sv
package nand_host_pkg;

	typedef enum logic [1:0] {
		KIND_CMD = 2'h0,
		KIND_ADDR = 2'h1,
		KIND_WDATA = 2'h2,
		KIND_RDATA = 2'h3
	} kind_e;

	// Gray codes along idle, setup, pulse, hold
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SETUP = 2'h1,
		ST_PULSE = 2'h3,
		ST_HOLD = 2'h2
	} bus_state_e;

endpackage

//--- src/word_buffer.sv
`timescale 1ns/100ps
module word_buffer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	typedef struct packed {
		logic v0;
		logic v1;
		logic [W-1:0] d0;
		logic [W-1:0] d1;
	} buf_s;

	buf_s s_r;
	buf_s s_nxt;

	always_comb begin
		logic push;
		logic pop;
		push = in_valid && !s_r.v1;
		pop = out_ready && s_r.v0;
		s_nxt = s_r;
		if (pop) begin
			s_nxt.d0 = s_r.d1;
			s_nxt.v0 = s_r.v1;
			s_nxt.v1 = 1'b0;
		end
		if (push) begin
			if (!s_nxt.v0) begin
				s_nxt.d0 = in_data;
				s_nxt.v0 = 1'b1;
			end else begin
				s_nxt.d1 = in_data;
				s_nxt.v1 = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign in_ready = !s_r.v1;
	assign out_valid = s_r.v0;
	assign out_data = s_r.d0;

	AST_BUF_HOLD: assert property (@(posedge clk) disable iff (rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffered word changed while stalled");
endmodule

//--- src/nand_host.sv
// Contract
// - Commands, addresses, data share one IO_W-bit bus
// - Read strobe pulse moves one word out
// - Write strobe pulse moves one word in
// - Open-drain ready/busy, pulled high when idle
// - Bus is 8 or 16 wide, bidirectional
// - Upper byte carries data only
// - Command first, then addresses, then data; only command-first is enforced
`timescale 1ns/100ps
`include "nand_host_defs.svh"
module nand_host #(
	parameter int IO_W = 16,
	parameter bit LOCK_EN = 1'b0,
	parameter int IDLE_CE_CYC = `IDLE_CE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_kind,
	input wire logic [IO_W-1:0] req_data,
	output logic order_err,
	input wire logic wp_allow,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [IO_W-1:0] rd_data,
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic wp_n,
	output logic lock_strap,
	input wire logic [IO_W-1:0] io_in,
	output logic [IO_W-1:0] io_out,
	output logic io_oe,
	input wire logic ready_busy
);
	localparam logic [`CNT_W-1:0] LOW_CYC = `CNT_W'(`STROBE_LOW_CYC);
	localparam logic [`CNT_W-1:0] HIGH_CYC = `CNT_W'(`STROBE_HIGH_CYC);
	localparam logic [`CNT_W-1:0] IDLE_CYC = `CNT_W'(IDLE_CE_CYC);

	typedef struct packed {
		nand_host_pkg::bus_state_e st;
		logic [`CNT_W-1:0] cnt;
		nand_host_pkg::kind_e kind;
		logic rdy;
		logic err;
		logic open;
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic wp_n;
		logic lock;
		logic oe;
		logic [IO_W-1:0] io;
		logic push;
		logic [IO_W-1:0] rdat;
	} host_s;

	host_s s_r;
	host_s s_nxt;
	logic buf_in_ready;

	// Commands and addresses use only the low byte; the upper lines stay low
	function automatic logic [IO_W-1:0] low_byte(input logic [IO_W-1:0] d);
		logic [IO_W-1:0] r;
		r = '0;
		r[`CA_W-1:0] = d[`CA_W-1:0];
		return r;
	endfunction

	always_comb begin
		logic go;
		go = 1'b0;
		s_nxt = s_r;
		s_nxt.err = 1'b0;
		s_nxt.push = 1'b0;
		s_nxt.wp_n = wp_allow;
		unique case (s_r.st)
			nand_host_pkg::ST_IDLE: begin
				if (req_valid && s_r.rdy) begin
					if (nand_host_pkg::kind_e'(req_kind) != nand_host_pkg::KIND_CMD
						&& !s_r.open) begin
						s_nxt.err = 1'b1;
					end else begin
						s_nxt.kind = nand_host_pkg::kind_e'(req_kind);
						s_nxt.rdy = 1'b0;
						s_nxt.ce_n = 1'b0;
						s_nxt.cnt = '0;
						s_nxt.st = nand_host_pkg::ST_SETUP;
						// Latch enables are decoded from the kind; at most one high, none for data
						s_nxt.cle = nand_host_pkg::kind_e'(req_kind) == nand_host_pkg::KIND_CMD;
						s_nxt.ale = nand_host_pkg::kind_e'(req_kind) == nand_host_pkg::KIND_ADDR;
						s_nxt.oe = nand_host_pkg::kind_e'(req_kind) != nand_host_pkg::KIND_RDATA;
						if (nand_host_pkg::kind_e'(req_kind) == nand_host_pkg::KIND_WDATA) begin
							s_nxt.io = req_data;
						end else begin
							s_nxt.io = low_byte(req_data);
						end
						if (nand_host_pkg::kind_e'(req_kind) == nand_host_pkg::KIND_CMD) begin
							s_nxt.open = 1'b1;
						end
					end
				end else if (!s_r.ce_n) begin
					if (s_r.cnt == IDLE_CYC) begin
						// Release chip select so the target drops to standby
						s_nxt.ce_n = 1'b1;
						s_nxt.open = 1'b0;
						s_nxt.cnt = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + 1'b1;
					end
				end
			end
			nand_host_pkg::ST_SETUP: begin
				// Address and data cycles wait for ready; read cycles also wait for room in the buffer
				go = (s_r.kind == nand_host_pkg::KIND_CMD) || ready_busy;
				if (s_r.kind == nand_host_pkg::KIND_RDATA && !buf_in_ready) begin
					go = 1'b0;
				end
				if (go) begin
					s_nxt.st = nand_host_pkg::ST_PULSE;
					s_nxt.cnt = '0;
					if (s_r.kind == nand_host_pkg::KIND_RDATA) begin
						s_nxt.re_n = 1'b0;
					end else begin
						s_nxt.we_n = 1'b0;
					end
				end
			end
			nand_host_pkg::ST_PULSE: begin
				if (s_r.cnt + 1'b1 >= LOW_CYC) begin
					s_nxt.st = nand_host_pkg::ST_HOLD;
					s_nxt.cnt = '0;
					s_nxt.we_n = 1'b1;
					s_nxt.re_n = 1'b1;
					if (s_r.kind == nand_host_pkg::KIND_RDATA) begin
						s_nxt.rdat = io_in;
						s_nxt.push = 1'b1;
					end
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
				end
			end
			nand_host_pkg::ST_HOLD: begin
				if (s_r.cnt + 1'b1 >= HIGH_CYC) begin
					s_nxt.st = nand_host_pkg::ST_IDLE;
					s_nxt.cnt = '0;
					s_nxt.cle = 1'b0;
					s_nxt.ale = 1'b0;
					s_nxt.rdy = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt + 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= nand_host_pkg::ST_IDLE;
			s_r.kind <= nand_host_pkg::KIND_CMD;
			s_r.rdy <= 1'b1;
			s_r.ce_n <= 1'b1;
			s_r.we_n <= 1'b1;
			s_r.re_n <= 1'b1;
			s_r.lock <= LOCK_EN;
		end else begin
			s_r <= s_nxt;
		end
	end

	word_buffer #(
		.W(IO_W)
	) u_rd_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(s_r.push),
		.in_ready(buf_in_ready),
		.in_data(s_r.rdat),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	assign req_ready = s_r.rdy;
	assign order_err = s_r.err;
	assign ce_n = s_r.ce_n;
	assign cle = s_r.cle;
	assign ale = s_r.ale;
	assign we_n = s_r.we_n;
	assign read_strobe_n = s_r.re_n;
	assign wp_n = s_r.wp_n;
	assign lock_strap = s_r.lock;
	assign io_out = s_r.io;
	assign io_oe = s_r.oe;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_LATCH_ONEHOT: assert property (!(cle && ale))
		else $error("both latch enables high");
	AST_CA_LOW_BYTE: assert property ($fell(we_n) && (cle || ale) |->
		io_oe && io_out[IO_W-1:`CA_W] == '0)
		else $error("command or address uses upper lines");
	AST_WE_PULSE: assert property ($fell(we_n) |-> !ce_n ##1 we_n && read_strobe_n)
		else $error("write strobe not a one-cycle pulse");
	AST_RE_RELEASE: assert property (!read_strobe_n |-> !io_oe && !ce_n ##1 read_strobe_n)
		else $error("read strobe held or bus driven");
	AST_RD_CAPTURE: assert property ($rose(read_strobe_n) |->
		s_r.push && s_r.rdat == $past(io_in))
		else $error("read word not captured");
	AST_BUSY_WAIT: assert property ($fell(we_n) && !cle |-> $past(ready_busy))
		else $error("data or address strobe while busy");
	AST_ORDER: assert property (req_valid && req_ready &&
		req_kind != 2'h0 && !s_r.open |=> order_err && req_ready)
		else $error("out-of-order request not refused");
	AST_STANDBY: assert property (ce_n |->
		we_n && read_strobe_n && s_r.st == nand_host_pkg::ST_IDLE)
		else $error("strobe while deselected");
	AST_CE_RELEASE: assert property (!ce_n && !req_valid &&
		s_r.st == nand_host_pkg::ST_IDLE && s_r.cnt == IDLE_CYC |=> ce_n)
		else $error("chip select not released when idle");
	// Both levels are checked, one cycle behind the control input
	AST_WP_FOLLOW: assert property (!rst |=> wp_n == $past(wp_allow))
		else $error("write protect not following control");
	AST_LOCK: assert property (lock_strap == LOCK_EN)
		else $error("lock strap changed");

	COV_CMD: cover property ($fell(we_n) && cle);
	COV_ADDR: cover property ($fell(we_n) && ale);
	COV_READ: cover property ($fell(read_strobe_n));
	COV_BUF_FULL: cover property (!buf_in_ready);
endmodule

//--- sim/nand_dev_model.sv
`timescale 1ns/100ps
module nand_dev_model #(
	parameter int IO_W = 16
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic wp_n,
	input wire logic [IO_W-1:0] io_out,
	input wire logic busy,
	output logic [IO_W-1:0] io_in,
	output logic ready_busy
);
	logic [7:0] cmd_r = 8'h00;
	logic [7:0] addr_r = 8'h00;
	logic [IO_W-1:0] wdat_r = '0;
	logic [IO_W-1:0] word_r = IO_W'(16'hA5C3);
	// Pull-up holds the line high unless the die pulls it low
	assign ready_busy = busy ? 1'b0 : 1'b1;
	// Released bus shows the inverse word, never a stale copy
	assign io_in = (!ce_n && !read_strobe_n) ? word_r : ~word_r;
	always @(posedge we_n) begin
		if (!ce_n) begin
			if (cle) cmd_r <= io_out[7:0];
			else if (ale) addr_r <= io_out[7:0];
			else if (wp_n) wdat_r <= io_out;
		end
	end
	always @(posedge read_strobe_n) begin
		if (!ce_n) word_r <= word_r + IO_W'(16'h0101);
	end
endmodule

//--- sim/tb_nand_host.sv
`timescale 1ns/100ps
module tb_nand_host;
	logic clk = 0, rst = 1, req_valid = 0, wp_allow = 1, rd_ready = 0, busy = 0;
	logic [1:0] req_kind = 2'h0;
	logic [15:0] req_data = 16'h0000;
	logic req_ready, order_err, rd_valid, ce_n, cle, ale, we_n, rsn, wp_n, lock_strap, io_oe;
	logic ready_busy;
	logic [15:0] rd_data, io_in, io_out;
	int failures = 0, checks = 0, cyc = 0;
	always #50 clk = ~clk;
	nand_host #(.IO_W(16), .LOCK_EN(1'b1), .IDLE_CE_CYC(2)) dut (.clk(clk), .rst(rst),
		.req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_data(req_data),
		.order_err(order_err), .wp_allow(wp_allow), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(rsn), .wp_n(wp_n), .lock_strap(lock_strap), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .ready_busy(ready_busy));
	nand_dev_model #(.IO_W(16)) dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(rsn), .wp_n(wp_n), .io_out(io_out), .busy(busy), .io_in(io_in),
		.ready_busy(ready_busy));
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic send(input logic [1:0] k, input logic [15:0] d);
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b1;
		req_kind <= k;
		req_data <= d;
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	task automatic idle();
		do @(negedge clk); while (req_ready !== 1'b1);
	endtask
	task automatic t_reset();
		chk("ce_n", 1, ce_n);
		chk("strobes", 2'b11, {we_n, rsn});
		chk("io_oe", 0, io_oe);
		chk("lock", 1, lock_strap);
	endtask
	task automatic t_order();
		send(2'h1, 16'h0033);
		@(negedge clk);
		chk("order_err", 1, order_err);
		chk("req_ready", 1, req_ready);
	endtask
	task automatic t_write();
		send(2'h0, 16'hFF80);
		@(posedge clk) busy <= 1'b1;
		send(2'h1, 16'h005A);
		repeat (4) @(negedge clk);
		chk("we busy", 1, we_n);
		chk("ready busy", 0, req_ready);
		@(posedge clk) busy <= 1'b0;
		send(2'h2, 16'hBEEF);
		idle();
		chk("cmd", 16'h0080, {8'h00, dev.cmd_r});
		chk("addr", 16'h005A, {8'h00, dev.addr_r});
		chk("wdata", 16'hBEEF, dev.wdat_r);
	endtask
	task automatic t_protect();
		@(posedge clk) wp_allow <= 1'b0;
		send(2'h0, 16'h0085);
		send(2'h2, 16'h1111);
		idle();
		chk("wp_n", 0, wp_n);
		chk("wdata", 16'hBEEF, dev.wdat_r);
		@(posedge clk) wp_allow <= 1'b1;
	endtask
	task automatic t_read();
		logic [15:0] ex[3] = '{16'hA5C3, 16'hA6C4, 16'hA7C5};
		int i;
		send(2'h0, 16'h0000);
		@(posedge clk) busy <= 1'b1;
		send(2'h3, 16'h0000);
		repeat (6) @(negedge clk);
		chk("strobe busy", 1, rsn);
		chk("ready busy", 0, req_ready);
		chk("io_oe read", 0, io_oe);
		@(posedge clk) busy <= 1'b0;
		send(2'h3, 16'h0000);
		send(2'h3, 16'h0000);
		repeat (6) @(negedge clk);
		chk("strobe full", 1, rsn);
		chk("ready full", 0, req_ready);
		chk("rd_valid", 1, rd_valid);
		chk("held word", ex[0], rd_data);
		@(posedge clk) rd_ready <= 1'b1;
		i = 0;
		while (i < 3) begin
			@(negedge clk);
			if (rd_valid === 1'b1) begin
				chk("rd_data", ex[i], rd_data);
				i++;
			end
		end
		@(posedge clk) rd_ready <= 1'b0;
	endtask
	task automatic t_standby();
		idle();
		repeat (6) @(negedge clk);
		chk("ce_n idle", 1, ce_n);
		send(2'h2, 16'h2222);
		@(negedge clk);
		chk("order_err", 1, order_err);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		repeat (11) @(posedge clk);
		@(negedge clk);
		t_reset();
		@(posedge clk) rst <= 1'b0;
		t_order();
		t_write();
		t_protect();
		t_read();
		t_standby();
		end_sim();
	end
endmodule
